// ---- core/typea_act_pkg.sv ----
// constants, types and encodings for the type a halt / rats / ats handler
// assumes one 250 mhz clock shared by the byte demodulator and modulator
package typea_act_pkg;

    // ==========================================================
    // timing
    localparam int CLK_PERIOD_PS = 4000;
    localparam int QUIET_TIME_US = 1000;
    localparam int QUIET_CYCLES  = (QUIET_TIME_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // ==========================================================
    // command frames
    localparam logic [2:0] CMD_LEN      = 3'h4;
    localparam logic [2:0] CNT_SAT      = 3'h7;
    localparam logic [7:0] HLTA_B0      = 8'h50;
    localparam logic [7:0] HLTA_B1      = 8'h00;
    localparam logic [7:0] RATS_START   = 8'he0;
    localparam logic [3:0] CID_FORBID   = 4'hf;
    localparam logic [3:0] FSDI_TOP     = 4'h8;
    localparam logic [3:0] FSDI_BIG     = 4'hf;

    // ==========================================================
    // answer to select
    localparam logic [7:0] ATS_TL       = 8'h05;
    localparam logic [7:0] ATS_T0       = 8'h78;
    localparam logic [7:0] ATS_TA       = 8'h80;
    localparam logic [3:0] ATS_SFGI     = 4'h0;
    localparam logic [7:0] ATS_TC       = 8'h00;
    localparam logic [2:0] IDX_TL       = 3'h0;
    localparam logic [2:0] IDX_T0       = 3'h1;
    localparam logic [2:0] IDX_TA       = 3'h2;
    localparam logic [2:0] IDX_TB       = 3'h3;
    localparam logic [2:0] IDX_TC       = 3'h4;
    localparam logic [2:0] IDX_CRC_LO   = 3'h5;
    localparam logic [2:0] IDX_CRC_HI   = 3'h6;
    localparam logic [3:0] FWI_MIN      = 4'h1;
    localparam logic [3:0] FWI_MAX      = 4'he;
    localparam logic [3:0] FWI_RESET    = 4'h4;

    // ==========================================================
    // crc_a
    localparam logic [15:0] CRC_INIT    = 16'h6363;
    localparam logic [15:0] CRC_POLY    = 16'h8408;
    localparam logic [15:0] CRC_RESIDUE = 16'h0000;

    // ==========================================================
    // register map, byte addresses
    localparam int          ADDR_W      = 4;
    localparam logic [3:0]  REG_CTRL    = 4'h0;
    localparam logic [3:0]  REG_STATUS  = 4'h4;
    localparam logic [3:0]  REG_DISCARD = 4'h8;
    localparam int          CTRL_EN     = 0;
    localparam int          CTRL_FWI    = 4;
    localparam int          CTRL_WAKE   = 8;
    localparam logic        EN_RESET    = 1'b1;
    localparam int          STS_STATE   = 0;
    localparam int          STS_CID     = 4;
    localparam int          STS_FSDI    = 8;
    localparam int          STS_CIDOK   = 12;
    localparam int          STS_QUIET   = 13;
    localparam logic [7:0]  DISC_MAX    = 8'hff;

    // ==========================================================
    // states and carriers
    typedef enum logic [3:0] {
        ST_IDLE   = 4'h1,
        ST_SEND   = 4'h2,
        ST_ACTIVE = 4'h4,
        ST_HALT   = 4'h8
    } state_t;

    typedef struct packed {
        logic       valid;
        logic       endf;
        logic [7:0] data;
    } rx_t;

    typedef struct packed {
        logic       valid;
        logic       last;
        logic [7:0] data;
    } tx_t;

endpackage

// ---- core/crc_a_acc.sv ----
// crc_a accumulator, one byte per enabled cycle, lsb first
// assumes clear and en come from logic on the same clock
`timescale 1ns/100ps
`default_nettype none

module crc_a_acc (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        ce,
    input  wire logic        clear,
    input  wire logic        en,
    input  wire logic [7:0]  data,
    output logic      [15:0] crc,
    output logic      [15:0] crc_nxt
);

    typedef struct packed {
        logic [15:0] crc;
    } acc_t;

    acc_t s_reg;
    acc_t s_next;

    function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c ^ {8'h00, d};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ typea_act_pkg::CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction

    // ==========================================================
    // update
    always_comb begin
        logic [15:0] base;
        base   = clear ? typea_act_pkg::CRC_INIT : s_reg.crc;
        s_next = s_reg;
        s_next.crc = en ? crc_byte(base, data) : base;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_reg.crc <= typea_act_pkg::CRC_INIT;
        end else if (ce) begin
            s_reg <= s_next;
        end
    end

    assign crc     = s_reg.crc;
    assign crc_nxt = s_next.crc;

endmodule // crc_a_acc

`default_nettype wire

// ---- core/typea_act.sv ----
// type a halt and rats handling with ats reply fixed except for the register-set fwi, and avalon registers
// assumes rx bytes and tx_ready come from logic on clk; reset on field entry
//
// Summary of operation
// R01 - after a valid halt command 0x5000, nothing is sent for 1 ms
// R02 - a valid halt frame moves the card into the halt state; the code takes it only in idle with en set
// R03 - reader sends start 0xe0, parameter byte, then two crc bytes
// R04 - parameter high nibble gives fsd index, 0..8 and 0xf accepted
// R05 - fsd index 0x9 to 0xe is stored as 0xf
// R06 - parameter low nibble is the card address, kept for later blocks
// R07 - address 15 gives no answer and returns the card to idle
// R08 - first answer byte is length 0x05, crc bytes not counted
// R09 - format byte is 0x78
// R10 - interface byte ta is 0x80, symmetric 106 kbit/s only
// R11 - tb holds frame waiting index 1..14 high, start guard 0 low
// R12 - reader derives start guard time from the zero guard index
// R13 - tc is 0x00, no address or node support flagged
// R14 - no historical bytes, crc follows tc directly
// R15 - bad crc or wrong length frames are dropped with no state change
//
// Register access over Avalon-MM and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

module typea_act #(
    parameter int unsigned QUIET_CYCLES = typea_act_pkg::QUIET_CYCLES
) (
    input  wire logic                              clk,
    input  wire logic                              nrst,
    input  wire logic                              ce,
    input  wire typea_act_pkg::rx_t                rx,
    input  wire logic                              tx_ready,
    output typea_act_pkg::tx_t                     tx,
    output logic [3:0]                             cid,
    output logic [3:0]                             fsdi,
    output logic                                   cid_valid,
    input  wire logic [typea_act_pkg::ADDR_W-1:0]  avs_address,
    input  wire logic                              avs_read,
    input  wire logic                              avs_write,
    input  wire logic [31:0]                       avs_writedata,
    input  wire logic [3:0]                        avs_byteenable,
    output logic [31:0]                            avs_readdata,
    output logic                                   avs_waitrequest
);

    localparam int QW = $clog2(QUIET_CYCLES + 1);

    typedef struct packed {
        typea_act_pkg::state_t st;
        logic [2:0]            rx_cnt;
        logic [7:0]            b0;
        logic [7:0]            b1;
        logic [2:0]            idx;
        typea_act_pkg::tx_t    tx;
        logic                  en;
        logic [3:0]            fwi;
        logic [3:0]            cid;
        logic [3:0]            fsdi;
        logic                  cid_ok;
        logic [QW-1:0]         quiet;
        logic [7:0]            disc;
        logic                  wreq;
        logic [31:0]           rdata;
    } core_t;

    core_t s_reg;
    core_t s_next;

    logic [15:0] rx_crc;
    logic [15:0] tx_crc;
    logic [15:0] tx_crc_nxt;
    logic        tx_take;
    logic        good;
    logic        ev_hlta;
    logic        ev_rats;
    logic        ev_cid15;
    logic        ev_start;
    logic        ev_bad;
    logic        listen;

    // ==========================================================
    // helpers
    function automatic logic [7:0] ats_byte(input logic [2:0] i, input logic [3:0] fwi);
        case (i)
            typea_act_pkg::IDX_TL: ats_byte = typea_act_pkg::ATS_TL;          // R08
            typea_act_pkg::IDX_T0: ats_byte = typea_act_pkg::ATS_T0;          // R09
            typea_act_pkg::IDX_TA: ats_byte = typea_act_pkg::ATS_TA;          // R10
            typea_act_pkg::IDX_TB: ats_byte = {fwi, typea_act_pkg::ATS_SFGI}; // R11 R12
            default:               ats_byte = typea_act_pkg::ATS_TC;          // R13
        endcase
    endfunction

    function automatic logic [3:0] fsdi_map(input logic [3:0] f);
        fsdi_map = (f <= typea_act_pkg::FSDI_TOP) ? f : typea_act_pkg::FSDI_BIG; // R04 R05
    endfunction

    function automatic logic [3:0] fwi_clamp(input logic [3:0] f);
        if (f < typea_act_pkg::FWI_MIN) begin
            fwi_clamp = typea_act_pkg::FWI_MIN;
        end else if (f > typea_act_pkg::FWI_MAX) begin
            fwi_clamp = typea_act_pkg::FWI_MAX;
        end else begin
            fwi_clamp = f;
        end
    endfunction

    // ==========================================================
    // crc on both directions
    crc_a_acc u_rx_crc (
        .clk     (clk),
        .nrst    (nrst),
        .ce      (ce),
        .clear   (rx.endf),
        .en      (rx.valid && !rx.endf),
        .data    (rx.data),
        .crc     (rx_crc),
        .crc_nxt ()
    );

    assign tx_take = (s_reg.st == typea_act_pkg::ST_SEND) && s_reg.tx.valid && tx_ready;

    crc_a_acc u_tx_crc (
        .clk     (clk),
        .nrst    (nrst),
        .ce      (ce),
        .clear   (ev_start),
        .en      (tx_take && (s_reg.idx <= typea_act_pkg::IDX_TC)),
        .data    (s_reg.tx.data),
        .crc     (tx_crc),
        .crc_nxt (tx_crc_nxt)
    );

    // ==========================================================
    // frame decisions
    assign listen   = rx.endf && s_reg.en && (s_reg.st == typea_act_pkg::ST_IDLE);
    assign good     = (s_reg.rx_cnt == typea_act_pkg::CMD_LEN)
                      && (rx_crc == typea_act_pkg::CRC_RESIDUE);              // R15
    assign ev_hlta  = listen && good && (s_reg.b0 == typea_act_pkg::HLTA_B0)
                      && (s_reg.b1 == typea_act_pkg::HLTA_B1);                // R01
    assign ev_rats  = listen && good && (s_reg.b0 == typea_act_pkg::RATS_START); // R03
    assign ev_cid15 = ev_rats && (s_reg.b1[3:0] == typea_act_pkg::CID_FORBID);   // R07
    assign ev_start = ev_rats && !ev_cid15 && (s_reg.quiet == '0);               // R01
    assign ev_bad   = listen && !ev_hlta && !ev_rats;                            // R15

    // ==========================================================
    // next state
    always_comb begin
        logic [2:0] nidx;
        nidx   = s_reg.idx + 3'h1;
        s_next = s_reg;

        if (s_reg.quiet != '0) begin
            s_next.quiet = s_reg.quiet - QW'(1);
        end

        if (rx.endf) begin
            s_next.rx_cnt = '0;
        end else if (rx.valid) begin
            if (s_reg.rx_cnt == '0) begin
                s_next.b0 = rx.data;
            end
            if (s_reg.rx_cnt == 3'h1) begin
                s_next.b1 = rx.data;
            end
            if (s_reg.rx_cnt != typea_act_pkg::CNT_SAT) begin
                s_next.rx_cnt = s_reg.rx_cnt + 3'h1;
            end
        end

        if (ev_hlta) begin
            s_next.st    = typea_act_pkg::ST_HALT;                             // R02
            s_next.quiet = QW'(QUIET_CYCLES);                                  // R01
        end else if (ev_cid15) begin
            s_next.st = typea_act_pkg::ST_IDLE;                                // R07
        end else if (ev_start) begin
            s_next.cid      = s_reg.b1[3:0];                                   // R06
            s_next.cid_ok   = 1'b1;
            s_next.fsdi     = fsdi_map(s_reg.b1[7:4]);                         // R04 R05
            s_next.st       = typea_act_pkg::ST_SEND;
            s_next.idx      = typea_act_pkg::IDX_TL;
            s_next.tx.valid = 1'b1;
            s_next.tx.last  = 1'b0;
            s_next.tx.data  = ats_byte(typea_act_pkg::IDX_TL, s_reg.fwi);      // R08
        end else if (ev_bad && (s_reg.disc != typea_act_pkg::DISC_MAX)) begin
            s_next.disc = s_reg.disc + 8'h01;                                  // R15
        end

        if (tx_take) begin
            if (s_reg.idx == typea_act_pkg::IDX_CRC_HI) begin
                s_next.tx.valid = 1'b0;
                s_next.tx.last  = 1'b0;
                s_next.st       = typea_act_pkg::ST_ACTIVE;
            end else begin
                s_next.idx     = nidx;
                s_next.tx.last = (nidx == typea_act_pkg::IDX_CRC_HI);          // R14
                if (nidx == typea_act_pkg::IDX_CRC_LO) begin
                    s_next.tx.data = tx_crc_nxt[7:0];                          // R14
                end else if (nidx == typea_act_pkg::IDX_CRC_HI) begin
                    s_next.tx.data = tx_crc[15:8];
                end else begin
                    s_next.tx.data = ats_byte(nidx, s_reg.fwi);
                end
            end
        end

        // register slave, one wait cycle per access
        if (!s_reg.wreq) begin
            s_next.wreq = 1'b1;
        end else if (avs_read || avs_write) begin
            s_next.wreq  = 1'b0;
            s_next.rdata = '0;
            if (avs_read) begin
                case (avs_address)
                    typea_act_pkg::REG_CTRL: begin
                        s_next.rdata[typea_act_pkg::CTRL_EN]       = s_reg.en;
                        s_next.rdata[typea_act_pkg::CTRL_FWI +: 4] = s_reg.fwi;
                    end
                    typea_act_pkg::REG_STATUS: begin
                        s_next.rdata[typea_act_pkg::STS_STATE +: 4] = s_reg.st;
                        s_next.rdata[typea_act_pkg::STS_CID +: 4]   = s_reg.cid;
                        s_next.rdata[typea_act_pkg::STS_FSDI +: 4]  = s_reg.fsdi;
                        s_next.rdata[typea_act_pkg::STS_CIDOK]      = s_reg.cid_ok;
                        s_next.rdata[typea_act_pkg::STS_QUIET]      = (s_reg.quiet != '0);
                    end
                    typea_act_pkg::REG_DISCARD: begin
                        s_next.rdata[7:0] = s_reg.disc;
                    end
                    default: begin
                        s_next.rdata = '0;
                    end
                endcase
            end else if (avs_address == typea_act_pkg::REG_CTRL) begin
                if (avs_byteenable[0]) begin
                    s_next.en  = avs_writedata[typea_act_pkg::CTRL_EN];
                    s_next.fwi = fwi_clamp(avs_writedata[typea_act_pkg::CTRL_FWI +: 4]); // R11
                end
                if (avs_byteenable[1] && avs_writedata[typea_act_pkg::CTRL_WAKE]
                    && ((s_reg.st == typea_act_pkg::ST_HALT)
                        || (s_reg.st == typea_act_pkg::ST_ACTIVE))) begin
                    s_next.st     = typea_act_pkg::ST_IDLE;
                    s_next.cid_ok = 1'b0;
                end
            end else if ((avs_address == typea_act_pkg::REG_DISCARD) && avs_byteenable[0]) begin
                s_next.disc = ev_bad ? 8'h01 : 8'h00;                          // R15
            end
        end
    end

    // ==========================================================
    // state register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_reg.st     <= typea_act_pkg::ST_IDLE;
            s_reg.rx_cnt <= '0;
            s_reg.b0     <= '0;
            s_reg.b1     <= '0;
            s_reg.idx    <= '0;
            s_reg.tx     <= '0;
            s_reg.en     <= typea_act_pkg::EN_RESET;
            s_reg.fwi    <= typea_act_pkg::FWI_RESET;
            s_reg.cid    <= '0;
            s_reg.fsdi   <= '0;
            s_reg.cid_ok <= 1'b0;
            s_reg.quiet  <= '0;
            s_reg.disc   <= '0;
            s_reg.wreq   <= 1'b1;
            s_reg.rdata  <= '0;
        end else if (ce) begin
            s_reg <= s_next;
        end
    end

    assign tx              = s_reg.tx;
    assign cid             = s_reg.cid;
    assign fsdi            = s_reg.fsdi;
    assign cid_valid       = s_reg.cid_ok;
    assign avs_readdata    = s_reg.rdata;
    assign avs_waitrequest = s_reg.wreq;

    // ==========================================================
    // checks
    logic [QW:0] since;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            since <= '1;
        end else if (ce) begin
            if (ev_hlta) begin
                since <= '0;
            end else if (since != '1) begin
                since <= since + (QW+1)'(1);
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    property p_quiet;
        tx.valid |-> (since >= (QW+1)'(QUIET_CYCLES));
    endproperty
    a_quiet: assert property (p_quiet) else $error("transmit inside quiet time"); // R01

    property p_halt;
        (ev_hlta && ce) |=> (s_reg.st == typea_act_pkg::ST_HALT);
    endproperty
    a_halt: assert property (p_halt) else $error("halt frame did not halt"); // R02

    property p_fsdi_low;
        (ev_start && ce && (s_reg.b1[7:4] <= typea_act_pkg::FSDI_TOP))
            |=> (fsdi == $past(s_reg.b1[7:4]));
    endproperty
    a_fsdi_low: assert property (p_fsdi_low) else $error("fsd index not kept"); // R04

    property p_fsdi_big;
        (ev_start && ce && (s_reg.b1[7:4] > typea_act_pkg::FSDI_TOP))
            |=> (fsdi == typea_act_pkg::FSDI_BIG);
    endproperty
    a_fsdi_big: assert property (p_fsdi_big) else $error("rfu fsd index not mapped"); // R05

    property p_cid;
        (ev_start && ce) |=> (cid_valid && (cid == $past(s_reg.b1[3:0])));
    endproperty
    a_cid: assert property (p_cid) else $error("card address not stored"); // R06

    property p_cid15;
        (ev_cid15 && ce) |=> (!tx.valid && (s_reg.st == typea_act_pkg::ST_IDLE)) [*2];
    endproperty
    a_cid15: assert property (p_cid15) else $error("answer sent for address 15"); // R07

    property p_tl;
        (ev_start && ce) |=> (tx.valid && (tx.data == typea_act_pkg::ATS_TL));
    endproperty
    a_tl: assert property (p_tl) else $error("length byte wrong"); // R08

    property p_t0;
        (tx.valid && (s_reg.idx == typea_act_pkg::IDX_T0)) |-> (tx.data == typea_act_pkg::ATS_T0);
    endproperty
    a_t0: assert property (p_t0) else $error("format byte wrong"); // R09

    property p_ta;
        (tx.valid && (s_reg.idx == typea_act_pkg::IDX_TA)) |-> (tx.data == typea_act_pkg::ATS_TA);
    endproperty
    a_ta: assert property (p_ta) else $error("ta byte wrong"); // R10

    property p_tb;
        (tx.valid && (s_reg.idx == typea_act_pkg::IDX_TB))
            |-> ((tx.data[3:0] == typea_act_pkg::ATS_SFGI)
                 && (tx.data[7:4] >= typea_act_pkg::FWI_MIN)
                 && (tx.data[7:4] <= typea_act_pkg::FWI_MAX));
    endproperty
    a_tb: assert property (p_tb) else $error("tb byte wrong"); // R11

    property p_tc;
        (tx.valid && (s_reg.idx == typea_act_pkg::IDX_TC)) |-> (tx.data == typea_act_pkg::ATS_TC);
    endproperty
    a_tc: assert property (p_tc) else $error("tc byte wrong"); // R13

    property p_len;
        (tx.valid && tx_ready && ce && tx.last)
            |-> ((s_reg.idx == typea_act_pkg::IDX_CRC_HI) ##1 !tx.valid);
    endproperty
    a_len: assert property (p_len) else $error("answer length wrong"); // R14

    property p_bad;
        (ev_bad && ce) |=> ((s_reg.st == $past(s_reg.st)) && (cid == $past(cid)));
    endproperty
    a_bad: assert property (p_bad) else $error("bad frame changed state"); // R15

endmodule // typea_act

`default_nettype wire

// ---- verif/pcd_model.sv ----
// reader side model: sends type a frames with crc_a and takes answer bytes
// assumes the card's rx and tx ports run on the same clk
`timescale 1ns/100ps
`default_nettype none

module pcd_model (
    input  wire logic               clk,
    output typea_act_pkg::rx_t      rx,
    output logic                    tx_ready,
    input  wire typea_act_pkg::tx_t tx
);
    logic [7:0] got      [8];
    logic       got_last [8];
    logic       slow = 1'b0;
    initial begin
        rx = '0;
        tx_ready = 1'b0;
    end
    // crc_a, lsb first, sent low byte first
    function automatic logic [15:0] crc_a(input logic [7:0] b [8], input int n);
        logic [15:0] c;
        c = typea_act_pkg::CRC_INIT;
        for (int i = 0; i < n; i++) begin
            c = c ^ {8'h00, b[i]};
            for (int k = 0; k < 8; k++) begin
                c = c[0] ? ((c >> 1) ^ typea_act_pkg::CRC_POLY) : (c >> 1);
            end
        end
        return c;
    endfunction
    // start or code byte, parameter byte, two crc bytes, then end of frame
    task automatic send(input logic [7:0] b0, input logic [7:0] b1, input logic bad);
        logic [7:0]  f [8];
        logic [15:0] c;
        f[0] = b0;
        f[1] = b1;
        c = crc_a(f, 2) ^ {15'h0000, bad};
        f[2] = c[7:0];
        f[3] = c[15:8];
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            rx <= '{valid: 1'b1, endf: 1'b0, data: f[i]};
        end
        @(posedge clk);
        rx <= '{valid: 1'b0, endf: 1'b1, data: ~f[3]};
        @(posedge clk);
        rx <= '{valid: 1'b0, endf: 1'b0, data: f[3]};
    endtask
    // takes answer bytes for a number of cycles, every other cycle when slow
    task automatic collect(input int cycles, output int n);
        n = 0;
        for (int i = 0; i < cycles; i++) begin
            @(posedge clk);
            if (tx_ready && tx.valid === 1'b1 && n < 8) begin
                got[n] = tx.data;
                got_last[n] = tx.last;
                n++;
            end
            tx_ready <= (i == cycles - 1) ? 1'b0 : (slow ? ~tx_ready : 1'b1);
        end
    endtask
endmodule // pcd_model

`default_nettype wire

// ---- verif/testbench.sv ----
// self-checking bench for the halt / rats / ats handler
// assumes pcd_model as the reader and a short quiet window
`timescale 1ns/100ps
`default_nettype none

module testbench;
    localparam int QC = 50;
    logic               clk = 1'b0;
    logic               nrst = 1'b0;
    typea_act_pkg::rx_t rx;
    typea_act_pkg::tx_t tx;
    logic               tx_ready;
    logic [3:0]         cid;
    logic [3:0]         fsdi;
    logic               cid_valid;
    logic [3:0]         avs_address = 4'h0;
    logic               avs_read = 1'b0;
    logic               avs_write = 1'b0;
    logic [31:0]        avs_writedata = 32'h0;
    logic [31:0]        avs_readdata;
    logic               avs_waitrequest;
    logic [31:0]        r;
    int                 num_errors = 0;
    int                 n_checks = 0;
    always #2 clk = ~clk;
    typea_act #(.QUIET_CYCLES(QC)) u_typea_act (.clk(clk), .nrst(nrst), .ce(1'b1), .rx(rx),
        .tx_ready(tx_ready), .tx(tx), .cid(cid), .fsdi(fsdi), .cid_valid(cid_valid),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest));
    pcd_model u_pcd_model (.clk(clk), .rx(rx), .tx_ready(tx_ready), .tx(tx));
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
        int i;
        @(posedge clk);
        avs_read <= ~wr;
        avs_write <= wr;
        avs_address <= a;
        avs_writedata <= wd;
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            if (avs_waitrequest === 1'b0) break;
        end
        r = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (i == 20) begin
            num_errors++;
            $display("Error waitrequest expected 0 seen %b", avs_waitrequest);
            tally_and_finish();
        end
    endtask
    task automatic no_answer(input string what);
        int n;
        u_pcd_model.collect(24, n);
        chk(what, 32'd0, 32'(n));
    endtask
    task automatic check_ats(input logic [3:0] fwi);
        logic [7:0]  e [8];
        logic [15:0] c;
        int          n;
        e = '{8'h05, 8'h78, 8'h80, {fwi, 4'h0}, 8'h00, 8'h00, 8'h00, 8'h00};
        c = u_pcd_model.crc_a(e, 5);
        e[5] = c[7:0];
        e[6] = c[15:8];
        u_pcd_model.collect(40, n);
        chk("ats count", 32'd7, 32'(n));
        for (int i = 0; i < 7; i++) begin
            chk("ats byte", {24'h0, e[i]}, {24'h0, u_pcd_model.got[i]});
        end
        chk("ats last", 32'd1, {31'h0, u_pcd_model.got_last[6]});
    endtask
    task automatic t_rats();
        u_pcd_model.send(8'he0, 8'h81, 1'b0);
        check_ats(4'h4);
        chk("cid", 32'h1, {28'h0, cid});
        chk("fsdi", 32'h8, {28'h0, fsdi});
        chk("cid_valid", 32'h1, {31'h0, cid_valid});
        bus(1'b0, 4'h4, 32'h0);
        chk("state", 32'h4, {28'h0, r[3:0]});
        $display("test rats done");
    endtask
    task automatic t_cid_fsdi();
        bus(1'b1, 4'h0, 32'h1e1);
        chk("cid_valid wake", 32'h0, {31'h0, cid_valid});
        u_pcd_model.send(8'he0, 8'haf, 1'b0);
        no_answer("cid15 bytes");
        bus(1'b0, 4'h4, 32'h0);
        chk("cid15 state", 32'h1, {28'h0, r[3:0]});
        u_pcd_model.slow = 1'b1;
        u_pcd_model.send(8'he0, 8'ha3, 1'b0);
        check_ats(4'he);
        u_pcd_model.slow = 1'b0;
        chk("fsdi mapped", 32'hf, {28'h0, fsdi});
        chk("cid 3", 32'h3, {28'h0, cid});
        $display("test cid and fsdi done");
    endtask
    task automatic t_halt();
        bus(1'b1, 4'h0, 32'h1e1);
        u_pcd_model.send(8'h50, 8'h00, 1'b1);
        bus(1'b0, 4'h8, 32'h0);
        chk("discard", 32'h1, {24'h0, r[7:0]});
        bus(1'b0, 4'h4, 32'h0);
        chk("bad crc state", 32'h1, {28'h0, r[3:0]});
        u_pcd_model.send(8'h50, 8'h00, 1'b0);
        bus(1'b0, 4'h4, 32'h0);
        chk("halt state", 32'h8, {28'h0, r[3:0]});
        chk("quiet", 32'h1, {31'h0, r[13]});
        u_pcd_model.send(8'he0, 8'h52, 1'b0);
        no_answer("rats in halt");
        bus(1'b1, 4'h0, 32'h1e1);
        u_pcd_model.send(8'he0, 8'h52, 1'b0);
        no_answer("rats in quiet");
        repeat (QC) @(posedge clk);
        u_pcd_model.send(8'he0, 8'h52, 1'b0);
        check_ats(4'he);
        bus(1'b0, 4'hc, 32'h0);
        chk("unmapped", 32'h0, r);
        $display("test halt done");
    endtask
    initial begin
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        t_rats();
        t_cid_fsdi();
        t_halt();
        tally_and_finish();
    end
endmodule // testbench

`default_nettype wire
